// >>> verilog/msc_pkg.sv
/*
  Constants, register map and carrier types of the serial channel.
  Assumes a 4-bit register index and 16-bit register data.
*/
package msc_pkg;
  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [3:0] ADR_MODE   = 4'h0;
  localparam logic [3:0] ADR_COMM   = 4'h1;
  localparam logic [3:0] ADR_SDR    = 4'h2;
  localparam logic [3:0] ADR_SO     = 4'h3;
  localparam logic [3:0] ADR_POM    = 4'h4;
  localparam logic [3:0] ADR_PLAT   = 4'h5;
  localparam logic [3:0] ADR_PDIR   = 4'h6;
  localparam logic [3:0] ADR_TRIG   = 4'h7;
  localparam logic [3:0] ADR_ERRCLR = 4'h8;
  localparam logic [3:0] ADR_STAT   = 4'h9;
  localparam logic [3:0] ADR_IST    = 4'ha;
  localparam logic [3:0] ADR_IMSK   = 4'hb;
  localparam logic [3:0] ADR_SPS    = 4'hc;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_MODE = 16'h0020;
  localparam logic [15:0] RST_COMM = 16'h0087;
  localparam logic [15:0] RST_SO   = 16'h0101;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [7:0]  RST_PORT = 8'h00;
  localparam logic [7:0]  RST_PDIR = 8'hff;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int B_CKS  = 15;
  localparam int B_SIS  = 6;
  localparam int B_MDH  = 2;
  localparam int B_MDL  = 1;
  localparam int B_ISRC = 0;
  localparam int B_TXE  = 15;
  localparam int B_RXE  = 14;
  localparam int B_DAP  = 13;
  localparam int B_CKP  = 12;
  localparam int B_EOC  = 10;
  localparam int B_PTH  = 9;
  localparam int B_PTL  = 8;
  localparam int B_DIR  = 7;
  localparam int B_SLH  = 5;
  localparam int B_SLL  = 4;
  localparam int B_DLH  = 1;
  localparam int B_DLL  = 0;
  localparam int B_CKO  = 8;
  localparam int B_SO   = 0;
  localparam int B_CLKP = 5;
  localparam int B_DATP = 6;
  localparam int B_STOP = 0;
  localparam int B_STRT = 1;
  localparam int B_FECT = 2;
  localparam int B_PECT = 1;
  localparam int B_OVCT = 0;
  localparam int B_DIVH = 15;
  localparam int B_DIVL = 9;
  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] MD_CSI  = 2'b00;
  localparam logic [1:0] MD_UART = 2'b01;
  localparam logic [1:0] MD_I2C  = 2'b10;
  localparam logic [1:0] MD_BAD  = 2'b11;
  localparam logic [1:0] PT_NONE = 2'b00;
  localparam logic [1:0] PT_ZERO = 2'b01;
  localparam logic [1:0] PT_EVEN = 2'b10;
  localparam logic [1:0] SL_BAD  = 2'b11;
  localparam logic [1:0] DL_OFF  = 2'b00;
  localparam logic [1:0] DL_9    = 2'b01;
  localparam logic [1:0] DL_7    = 2'b10;
  localparam logic [3:0] LEN_9   = 4'd9;
  localparam logic [3:0] LEN_8   = 4'd8;
  localparam logic [3:0] LEN_7   = 4'd7;
  localparam logic [3:0] I2C_BITS = 4'd9;

  typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH} msc_state_t;

  typedef struct packed {
    logic o;
    logic oe;
  } msc_pin_t;
endpackage

// >>> verilog/msc_serial_channel.sv
/*
  One channel of a multi-mode serial unit (clocked serial, UART, simple I2C).
  Assumes a plain register port on mclk_in and pins already level shifted.
*/
`timescale 1ns/1ps
module msc_serial_channel #(
  parameter int CNT_W = 16,
  parameter int DIV_W = 7
) (
  input  wire logic              mclk_in,    // 100 MHz clock
  input  wire logic              reset_n_in, // async reset, low
  input  wire logic [3:0]        addr_in,    // register index
  input  wire logic [15:0]       wdata_in,   // write data
  input  wire logic              wr_in,      // write strobe
  input  wire logic              rd_in,      // read strobe
  output logic [15:0]            rdata_out,  // read data, next cycle
  input  wire logic              scl_in,     // clock pin level
  input  wire logic              sda_in,     // data pin level
  input  wire logic              uart_rx_pin_in, // UART receive pin
  output msc_pkg::msc_pin_t      scl_out,    // clock pin drive
  output msc_pkg::msc_pin_t      sda_out,    // data pin drive
  output logic                   irq_out     // level interrupt
);
  // ----------------------------------------------------------------
  // Elaboration checks and helpers
  // ----------------------------------------------------------------
  if (CNT_W != 16) $error("CNT_W must be 16");
  if (DIV_W != 7) $error("DIV_W must be 7");

  function automatic logic pre_tick(input logic [15:0] c, input logic [3:0] s);
    logic [15:0] m;
    m = (16'h0001 << s) - 16'h0001;
    return (c & m) == m;
  endfunction

  function automatic logic [15:0] build_frame(input logic [1:0] md,
      input logic [15:0] cfg, input logic [8:0] d, input logic [3:0] n);
    logic [8:0]  b;
    logic [15:0] f;
    logic        p;
    // Positions past the character stay high, so a UART frame ends at stop level.
    b = 9'h1ff;
    f = 16'h0000;
    p = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < n) begin
        b[i] = cfg[msc_pkg::B_DIR] ? d[i] : d[n - 4'(i) - 4'd1];
        p    = p ^ d[i];
      end
    end
    unique case (md)
      msc_pkg::MD_I2C: f = {7'h00, 1'b1, b[7:0]};
      msc_pkg::MD_UART: begin
        f = {6'h3f, b, 1'b0};
        if (cfg[msc_pkg::B_PTH:msc_pkg::B_PTL] != msc_pkg::PT_NONE) begin
          f[n + 4'd1] = cfg[msc_pkg::B_PTH] & (p ^ cfg[msc_pkg::B_PTL]);
        end
      end
      default: f = {7'h00, b};
    endcase
    return f;
  endfunction

  // ----------------------------------------------------------------
  // Registers and synchronisers
  // ----------------------------------------------------------------
  logic [15:0] mode, comm, sdr, so, sps;
  logic [7:0]  pom, plat, pdir;
  logic [1:0]  ist, imsk;
  logic        se, fe, pe, ove;
  logic [1:0]  sda_sy, rx_sy;
  logic [1:0]  scl_sy;
  logic [15:0] pre_cnt;
  logic [DIV_W-1:0] div_cnt;
  msc_pkg::msc_state_t state;
  logic [3:0]  bit_idx, nbits;
  logic [15:0] frame;
  logic        ack;

  wire [1:0] op_mode = {mode[msc_pkg::B_MDH], mode[msc_pkg::B_MDL]};
  wire [1:0] dls     = comm[msc_pkg::B_DLH:msc_pkg::B_DLL];
  wire [1:0] slc     = comm[msc_pkg::B_SLH:msc_pkg::B_SLL];
  wire       is_i2c  = op_mode == msc_pkg::MD_I2C;
  wire       is_uart = op_mode == msc_pkg::MD_UART;
  wire       busy    = state != msc_pkg::ST_IDLE;

  wire [3:0] char_len = (dls == msc_pkg::DL_9) ? msc_pkg::LEN_9 :
                        (dls == msc_pkg::DL_7) ? msc_pkg::LEN_7 : msc_pkg::LEN_8;
  // stop bits and parity widen the UART frame
  wire [3:0] uart_bits = char_len + 4'd1 + 4'(slc) +
                         4'(comm[msc_pkg::B_PTH:msc_pkg::B_PTL] != msc_pkg::PT_NONE);
  wire [3:0] frame_bits = is_i2c ? msc_pkg::I2C_BITS : is_uart ? uart_bits : char_len;

  // ----------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------
  wire wr_mode = wr_in && addr_in == msc_pkg::ADR_MODE;
  wire wr_comm = wr_in && addr_in == msc_pkg::ADR_COMM;
  wire wr_sdr  = wr_in && addr_in == msc_pkg::ADR_SDR;
  wire wr_so   = wr_in && addr_in == msc_pkg::ADR_SO;
  wire wr_pom  = wr_in && addr_in == msc_pkg::ADR_POM;
  wire wr_plat = wr_in && addr_in == msc_pkg::ADR_PLAT;
  wire wr_pdir = wr_in && addr_in == msc_pkg::ADR_PDIR;
  wire wr_trig = wr_in && addr_in == msc_pkg::ADR_TRIG;
  wire wr_eclr = wr_in && addr_in == msc_pkg::ADR_ERRCLR;
  wire wr_ist  = wr_in && addr_in == msc_pkg::ADR_IST;
  wire wr_imsk = wr_in && addr_in == msc_pkg::ADR_IMSK;
  wire wr_sps  = wr_in && addr_in == msc_pkg::ADR_SPS;
  wire stop_trig  = wr_trig && wdata_in[msc_pkg::B_STOP];
  wire start_trig = wr_trig && wdata_in[msc_pkg::B_STRT] && !stop_trig;

  // forbidden mode and prohibited lengths never start a transfer
  wire cfg_ok = op_mode != msc_pkg::MD_BAD && dls != msc_pkg::DL_OFF &&
                !(is_uart && slc == msc_pkg::SL_BAD) && comm[msc_pkg::B_TXE];
  wire start_xfer = wr_sdr && se && cfg_ok && !busy && !stop_trig;
  wire overrun_ev = wr_sdr && se && busy;

  // ----------------------------------------------------------------
  // Prescaler and transfer clock
  // ----------------------------------------------------------------
  // divide by two to the power of the selector
  wire ck0_tick = pre_tick(pre_cnt, sps[3:0]);
  wire ck1_tick = pre_tick(pre_cnt, sps[7:4]);
  wire mck_tick = mode[msc_pkg::B_CKS] ? ck1_tick : ck0_tick;
  wire half_done = busy && mck_tick && div_cnt == sdr[msc_pkg::B_DIVH:msc_pkg::B_DIVL];
  wire last_bit  = bit_idx == nbits - 4'd1;
  wire end_ev    = state == msc_pkg::ST_HIGH && half_done && last_bit;
  // The acknowledge sample lags the pins by three cycles, so halves need two or more.
  // acknowledge sampled on the ninth clock
  wire ack_now   = state == msc_pkg::ST_HIGH && half_done && is_i2c && last_bit;
  wire nack_ev   = end_ev && is_i2c && (ack_now ? sda_sy[1] : ack);

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pre_cnt <= 16'h0000;
      div_cnt <= '0;
    end else begin
      pre_cnt <= pre_cnt + 16'h0001;
      div_cnt <= (!busy || half_done) ? '0 : div_cnt + DIV_W'(mck_tick);
    end
  end

  // ----------------------------------------------------------------
  // Shift engine
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state   <= msc_pkg::ST_IDLE;
      bit_idx <= 4'h0;
      nbits   <= 4'h0;
      frame   <= 16'h0000;
      ack     <= 1'b1;
    end else begin
      unique case (state)
        msc_pkg::ST_IDLE: if (start_xfer) begin
          state   <= msc_pkg::ST_LOW;
          bit_idx <= 4'h0;
          nbits   <= frame_bits;
          frame   <= build_frame(op_mode, comm, wdata_in[8:0], char_len);
        end
        msc_pkg::ST_LOW: if (half_done) state <= msc_pkg::ST_HIGH;
        msc_pkg::ST_HIGH: if (half_done) begin
          if (ack_now) ack <= sda_sy[1];
          state   <= last_bit ? msc_pkg::ST_IDLE : msc_pkg::ST_LOW;
          bit_idx <= bit_idx + 4'd1;
        end
      endcase
      if (stop_trig) state <= msc_pkg::ST_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // Line levels
  // ----------------------------------------------------------------
  // in clocked serial mode polarity flips the clock, data phase leads data by half a bit
  wire [3:0] data_idx = bit_idx + 4'(comm[msc_pkg::B_DAP] && state == msc_pkg::ST_HIGH
                        && !is_i2c && !is_uart && !last_bit);
  wire eng_clk = (state == msc_pkg::ST_HIGH) ^ (comm[msc_pkg::B_CKP] && !is_i2c);
  // clock line from the clock-output bit while idle
  wire clk_lvl = (busy && !is_uart) ? eng_clk : so[msc_pkg::B_CKO];
  // data line from the data-output bit while idle
  wire dat_lvl = busy ? frame[data_idx] : so[msc_pkg::B_SO];
  wire clk_pin = clk_lvl & plat[msc_pkg::B_CLKP];
  wire dat_pin = dat_lvl & plat[msc_pkg::B_DATP];
  wire clk_drv = !pdir[msc_pkg::B_CLKP];
  wire dat_drv = !pdir[msc_pkg::B_DATP];
  wire clk_od  = pom[msc_pkg::B_CLKP];
  wire dat_od  = pom[msc_pkg::B_DATP];

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      scl_out <= '0;
      sda_out <= '0;
    end else begin
      scl_out <= '{o: clk_pin && !clk_od, oe: clk_drv && !(clk_od && clk_pin)};
      sda_out <= '{o: dat_pin && !dat_od, oe: dat_drv && !(dat_od && dat_pin)};
    end
  end

  // ----------------------------------------------------------------
  // Events, flags and interrupts
  // ----------------------------------------------------------------
  // transfer end or buffer empty
  wire chan_src = mode[msc_pkg::B_ISRC] ? start_xfer : end_ev;
  // acknowledge errors go to the error interrupt only when enabled
  wire err_ev   = nack_ev && comm[msc_pkg::B_EOC];
  wire chan_ev  = chan_src && !err_ev;
  wire [1:0] ist_set = {err_ev, chan_ev};
  wire [1:0] ist_clr = wr_ist ? wdata_in[1:0] : 2'b00;
  // receive level reversal in UART mode
  wire rx_lvl = rx_sy[1] ^ (is_uart && mode[msc_pkg::B_SIS]);

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      se  <= 1'b0;
      fe  <= 1'b0;
      pe  <= 1'b0;
      ove <= 1'b0;
      ist <= 2'b00;
    end else begin
      se  <= stop_trig ? 1'b0 : (se || start_trig);
      fe  <= fe && !(wr_eclr && wdata_in[msc_pkg::B_FECT]);
      pe  <= (pe && !(wr_eclr && wdata_in[msc_pkg::B_PECT])) || nack_ev;
      ove <= (ove && !(wr_eclr && wdata_in[msc_pkg::B_OVCT])) || overrun_ev;
      ist <= (ist & ~ist_clr) | ist_set;
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mode <= msc_pkg::RST_MODE;
      comm <= msc_pkg::RST_COMM;
      sdr  <= msc_pkg::RST_ZERO;
      so   <= msc_pkg::RST_SO;
      sps  <= msc_pkg::RST_ZERO;
      pom  <= msc_pkg::RST_PORT;
      plat <= msc_pkg::RST_PORT;
      pdir <= msc_pkg::RST_PDIR;
      imsk <= 2'b00;
      sda_sy <= 2'b11;
      scl_sy <= 2'b11;
      rx_sy  <= 2'b11;
    end else begin
      if (wr_mode) mode <= wdata_in;
      if (wr_comm) comm <= wdata_in;
      if (wr_sdr) sdr <= start_xfer || !se ? wdata_in : sdr;
      if (wr_so) so <= wdata_in;
      if (wr_sps) sps <= wdata_in;
      if (wr_pom) pom <= wdata_in[7:0];
      if (wr_plat) plat <= wdata_in[7:0];
      if (wr_pdir) pdir <= wdata_in[7:0];
      if (wr_imsk) imsk <= wdata_in[1:0];
      sda_sy <= {sda_sy[0], sda_in};
      scl_sy <= {scl_sy[0], scl_in};
      rx_sy  <= {rx_sy[0], uart_rx_pin_in};
    end
  end

  assign irq_out = |(ist & imsk);

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  wire [15:0] stat_word = {9'h000, scl_sy[1], rx_lvl, busy, se, fe, pe, ove};
  wire [15:0] rd_mux =
    addr_in == msc_pkg::ADR_MODE ? mode :
    addr_in == msc_pkg::ADR_COMM ? comm :
    addr_in == msc_pkg::ADR_SDR  ? sdr  :
    addr_in == msc_pkg::ADR_SO   ? so   :
    addr_in == msc_pkg::ADR_POM  ? {8'h00, pom}  :
    addr_in == msc_pkg::ADR_PLAT ? {8'h00, plat} :
    addr_in == msc_pkg::ADR_PDIR ? {8'h00, pdir} :
    addr_in == msc_pkg::ADR_STAT ? stat_word :
    addr_in == msc_pkg::ADR_IST  ? {14'h0000, ist}  :
    addr_in == msc_pkg::ADR_IMSK ? {14'h0000, imsk} :
    addr_in == msc_pkg::ADR_SPS  ? sps : 16'h0000;

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) rdata_out <= 16'h0000;
    else rdata_out <= rd_in ? rd_mux : 16'h0000;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);

  a_bad_mode_idle: assert property (wr_sdr && op_mode == msc_pkg::MD_BAD && !busy
    |=> !busy) else $error("forbidden mode started a transfer");
  a_end_irq_src: assert property (end_ev && !mode[msc_pkg::B_ISRC] && !err_ev
    |=> ist[0]) else $error("transfer end did not flag");
  a_empty_irq_src: assert property (start_xfer && mode[msc_pkg::B_ISRC]
    |=> ist[0] && busy) else $error("buffer empty did not flag");
  a_error_route: assert property (nack_ev && comm[msc_pkg::B_EOC] && !ist[0]
    |=> ist[1] && !ist[0]) else $error("error routed to end interrupt");
  a_len_off_idle: assert property (wr_sdr && dls == msc_pkg::DL_OFF && !busy
    |=> !busy) else $error("prohibited length started");
  a_i2c_nine: assert property (start_xfer && is_i2c
    |=> nbits == msc_pkg::I2C_BITS) else $error("I2C frame not nine bits");
  a_stop_halts: assert property (stop_trig
    |=> !se && !busy) else $error("stop trigger ignored");
  a_pe_clear: assert property (wr_eclr && wdata_in[msc_pkg::B_PECT] && !nack_ev
    |=> !pe) else $error("parity flag not cleared");
  a_presc_full: assert property (sps[3:0] == 4'h0 && !mode[msc_pkg::B_CKS]
    |-> mck_tick) else $error("undivided clock missing tick");
  a_clk_idle: assert property (!busy && !pdir[msc_pkg::B_CLKP] && !pom[msc_pkg::B_CLKP]
    && plat[msc_pkg::B_CLKP] ##1 !busy |-> scl_out.o == $past(so[msc_pkg::B_CKO]))
    else $error("clock line does not follow output bit");

  c_i2c_done: cover property (end_ev && is_i2c && !nack_ev);
  c_nack: cover property (nack_ev);
  c_overrun: cover property (overrun_ev);
  c_uart_go: cover property (start_xfer && is_uart);
endmodule

// >>> sim/msc_i2c_slave.sv
/*
  Behavioural I2C slave that receives bytes on a pulled-up two-wire bus.
  Assumes the bench resolves both lines and feeds the levels back here.
*/
`timescale 1ns/1ps
module msc_i2c_slave (
  input  wire logic       scl_in,      // resolved clock line
  input  wire logic       sda_in,      // resolved data line
  input  wire logic       ack_in,      // 1 acknowledges each byte
  input  wire logic       slow_in,     // 1 answers late in the low half
  output logic            sda_low_out, // pulls the data line low
  output logic [7:0]      byte_out     // last byte received
);
  int         cnt = 0;
  logic [7:0] sh = 8'h00;
  initial begin
    sda_low_out = 1'b0;
    byte_out = 8'h00;
  end
  // A data fall with the clock still high afterwards opens a frame.
  always @(negedge sda_in) begin
    #1;
    if (scl_in === 1'b1) begin
      cnt = 0;
    end
  end
  always @(posedge scl_in) begin
    if (cnt < 8) begin
      sh = {sh[6:0], sda_in};
      cnt = cnt + 1;
      if (cnt == 8) begin
        byte_out = sh;
      end
    end
  end
  always @(negedge scl_in) begin
    if (cnt == 8) begin
      sda_low_out <= #(slow_in ? 6 : 1) ack_in;
      cnt = 9;
    end else if (cnt == 9) begin
      sda_low_out <= #1 1'b0;
      cnt = 0;
    end
  end
endmodule

// >>> sim/msc_serial_channel_tb.sv
/*
  Self-checking bench of the serial channel running as an I2C master, a UART transmitter and a clocked serial master.
  Assumes pull-ups on both lines and the slave model on the far side.
*/
`timescale 1ns/1ps
module msc_serial_channel_tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic              mclk_in    = 1'b0;
  logic              reset_n_in = 1'b0;
  logic [3:0]        addr_in    = 4'h0;
  logic [15:0]       wdata_in   = 16'h0000;
  logic              wr_in      = 1'b0;
  logic              rd_in      = 1'b0;
  logic              rx_pin     = 1'b1;
  logic              ack_en     = 1'b1;
  logic              slow       = 1'b0;
  logic [15:0]       rdata_out;
  msc_pkg::msc_pin_t scl_out;
  msc_pkg::msc_pin_t sda_out;
  logic              irq_out;
  logic              slv_low;
  logic [7:0]        slv_byte;
  wire               scl_w = scl_out.oe ? scl_out.o : 1'b1;
  wire               sda_w = slv_low ? 1'b0 : (sda_out.oe ? sda_out.o : 1'b1);
  int                error_cnt = 0;
  int                compares = 0;
  int                seed = 32'h1439db1d;
  logic [7:0]        exp_q[$];
  int                i;
  logic [7:0]        ub;
  logic [10:0]       frm;
  logic [15:0]       rv [14] = '{16'h0020, 16'h0087, 0, 16'h0101, 0, 0, 16'h00ff,
                                 0, 0, 0, 0, 0, 0, 0};
  logic [15:0]       sps_t [4] = '{16'h0000, 16'h0020, 16'h0031, 16'h0031};
  int                dv_t [4] = '{0, 1, 2, 0};
  int                tk_t [4] = '{1, 4, 2, 8};
  logic [15:0]       md_t [4] = '{16'h0026, 16'h0024, 16'h0022, 16'h0024};
  logic [15:0]       cm_t [4] = '{16'h8017, 16'h8014, 16'h8037, 16'h0017};

  msc_serial_channel i_dut (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .scl_in(scl_w), .sda_in(sda_w), .uart_rx_pin_in(rx_pin),
    .scl_out(scl_out), .sda_out(sda_out), .irq_out(irq_out)
  );
  msc_i2c_slave i_slv (
    .scl_in(scl_w), .sda_in(sda_w), .ack_in(ack_en), .slow_in(slow),
    .sda_low_out(slv_low), .byte_out(slv_byte)
  );

  initial begin
    forever #5 mclk_in = ~mclk_in;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge mclk_in);
    addr_in  <= a;
    wdata_in <= v;
    wr_in    <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
    #1;
  endtask
  task automatic rchk(input string nm, input logic [3:0] a, input logic [15:0] e,
                      input logic [15:0] m);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1;
    chk(nm, e & m, rdata_out & m);
  endtask
  task automatic bitchk(input string nm, input logic e, input logic g);
    chk(nm, {15'h0000, e}, {15'h0000, g});
  endtask
  task automatic xfer(input int dv, input int tk);
    logic [7:0] b;
    int         c;
    int         n;
    b = 8'($random(seed));
    exp_q.push_back(b);
    wr(msc_pkg::ADR_SDR, {dv[6:0], 1'b0, b});
    c = 0;
    while (irq_out !== 1'b1 && c < 3000) begin
      @(posedge mclk_in);
      #1;
      c++;
    end
    n = 18 * (dv + 1) * tk;
    bitchk("xfer_time", 1'b1, c > n - tk && c <= n);
    chk("slave_byte", {8'h00, exp_q.pop_front()}, {8'h00, slv_byte});
  endtask
  task automatic end_of_test;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    for (i = 0; i < 14; i++) begin
      rchk("reset_value", 4'(i), rv[i], (i == 2 || i inside {[7:9]}) ? 0 : 16'hffff);
    end
    wr(msc_pkg::ADR_POM, 16'h01ff);
    rchk("port_width", msc_pkg::ADR_POM, 16'h00ff, 16'hffff);
    wr(msc_pkg::ADR_POM, 16'h0060);
    wr(msc_pkg::ADR_PLAT, 16'h0060);
    wr(msc_pkg::ADR_PDIR, 16'h0000);
    for (i = 0; i < 8; i++) begin
      wr(msc_pkg::ADR_POM, {9'h000, {2{i[2]}}, 5'h00});
      wr(msc_pkg::ADR_SO, {7'h00, i[1], 7'h00, i[0]});
      repeat (3) @(posedge mclk_in);
      bitchk("scl_line", i[1], scl_w);
      bitchk("sda_line", i[0], sda_w);
    end
    wr(msc_pkg::ADR_SO, 16'h0100);
    wr(msc_pkg::ADR_SO, 16'h0000);
    wr(msc_pkg::ADR_COMM, 16'h8017);
    wr(msc_pkg::ADR_IMSK, 16'h0003);
    wr(msc_pkg::ADR_TRIG, 16'h0002);
    rchk("enable", msc_pkg::ADR_STAT, 16'h0008, 16'h0008);
    for (i = 0; i < 4; i++) begin
      slow = i[0];
      wr(msc_pkg::ADR_SPS, sps_t[i]);
      wr(msc_pkg::ADR_MODE, {(i > 0 && i != 2), 15'h0024});
      xfer(dv_t[i], tk_t[i]);
      rchk("ist_end", msc_pkg::ADR_IST, 16'h0001, 16'hffff);
      wr(msc_pkg::ADR_IMSK, 16'h0002);
      bitchk("irq_masked", 1'b0, irq_out);
      wr(msc_pkg::ADR_IMSK, 16'h0003);
      bitchk("irq_open", 1'b1, irq_out);
      wr(msc_pkg::ADR_IST, 16'h0001);
      rchk("ist_clear", msc_pkg::ADR_IST, 16'h0000, 16'hffff);
    end
    ack_en = 1'b0;
    xfer(0, 8);
    rchk("nack_ist", msc_pkg::ADR_IST, 16'h0001, 16'hffff);
    rchk("nack_flag", msc_pkg::ADR_STAT, 16'h0002, 16'h0002);
    wr(msc_pkg::ADR_ERRCLR, 16'h0000);
    rchk("flag_kept", msc_pkg::ADR_STAT, 16'h0002, 16'h0002);
    wr(msc_pkg::ADR_ERRCLR, 16'h0002);
    rchk("flag_clear", msc_pkg::ADR_STAT, 16'h0000, 16'h0002);
    wr(msc_pkg::ADR_IST, 16'h0001);
    wr(msc_pkg::ADR_COMM, 16'h8417);
    xfer(0, 8);
    rchk("err_irq", msc_pkg::ADR_IST, 16'h0002, 16'hffff);
    wr(msc_pkg::ADR_IST, 16'h0002);
    wr(msc_pkg::ADR_ERRCLR, 16'h0002);
    wr(msc_pkg::ADR_COMM, 16'h8017);
    ack_en = 1'b1;
    wr(msc_pkg::ADR_MODE, 16'h8025);
    wr(msc_pkg::ADR_SDR, {7'd20, 9'h0a5});
    rchk("ist_start", msc_pkg::ADR_IST, 16'h0001, 16'hffff);
    wr(msc_pkg::ADR_SDR, 16'h0000);
    rchk("overrun", msc_pkg::ADR_STAT, 16'h0001, 16'h0001);
    wr(msc_pkg::ADR_TRIG, 16'h0000);
    rchk("se_kept", msc_pkg::ADR_STAT, 16'h0008, 16'h0008);
    wr(msc_pkg::ADR_TRIG, 16'h0001);
    rchk("se_clear", msc_pkg::ADR_STAT, 16'h0000, 16'h0008);
    wr(msc_pkg::ADR_ERRCLR, 16'h0001);
    rchk("ovr_clear", msc_pkg::ADR_STAT, 16'h0000, 16'h0001);
    wr(msc_pkg::ADR_IST, 16'h0003);
    wr(msc_pkg::ADR_SO, 16'h0101);
    wr(msc_pkg::ADR_SO, 16'h0100);
    wr(msc_pkg::ADR_SO, 16'h0000);
    for (i = 0; i < 4; i++) begin
      wr(msc_pkg::ADR_MODE, md_t[i]);
      wr(msc_pkg::ADR_COMM, cm_t[i]);
      wr(msc_pkg::ADR_TRIG, 16'h0002);
      wr(msc_pkg::ADR_SDR, 16'h0055);
      repeat (60) @(posedge mclk_in);
      rchk("refused", msc_pkg::ADR_IST, 16'h0000, 16'hffff);
    end
    // A UART frame sent LSB first with even parity, sampled mid-bit.
    ack_en = 1'b0;
    wr(msc_pkg::ADR_SPS, 16'h0000);
    wr(msc_pkg::ADR_MODE, 16'h0022);
    wr(msc_pkg::ADR_COMM, 16'h8297);
    ub = 8'($random(seed));
    frm = {1'b1, ^ub, ub, 1'b0};
    wr(msc_pkg::ADR_SDR, {7'd3, 1'b0, ub});
    repeat (5) @(posedge mclk_in);
    for (i = 0; i < 11; i++) begin
      #1;
      bitchk("uart_bit", frm[i], sda_w);
      repeat (8) @(posedge mclk_in);
    end
    rchk("uart_end", msc_pkg::ADR_IST, 16'h0001, 16'hffff);
    wr(msc_pkg::ADR_IST, 16'h0001);
    // A type 4 clocked serial frame: clock is high in the first half of each bit, data leads by half a bit.
    ub = 8'($random(seed));
    wr(msc_pkg::ADR_MODE, 16'h0020);
    wr(msc_pkg::ADR_COMM, 16'hb017);
    wr(msc_pkg::ADR_SDR, {7'd3, 1'b0, ub});
    repeat (3) @(posedge mclk_in);
    for (i = 0; i < 16; i++) begin
      #1;
      bitchk("csi_clk", !i[0], scl_w);
      bitchk("csi_data", ub[(i == 15) ? 0 : 7 - (i + 1) / 2], sda_w);
      repeat (4) @(posedge mclk_in);
    end
    rchk("csi_end", msc_pkg::ADR_IST, 16'h0001, 16'hffff);
    wr(msc_pkg::ADR_IST, 16'h0001);
    for (i = 0; i < 4; i++) begin
      wr(msc_pkg::ADR_MODE, i[0] ? 16'h0062 : 16'h0022);
      rx_pin <= 1'($random(seed));
      repeat (4) @(posedge mclk_in);
      rchk("rx_level", msc_pkg::ADR_STAT, {10'h000, rx_pin ^ i[0], 5'h00}, 16'h0020);
    end
    end_of_test();
  end
  initial begin
    #500000;
    error_cnt++;
    end_of_test();
  end
endmodule
